// ---- cdr_top.sv ----
// Function
// - 16-bit unsigned output code register, zero after reset.
// - narrow variant keeps upper bits; low bits ignored on write, read zero.
// - 16-bit unsigned gain trim register, zero after reset.
// - 16-bit signed offset trim register, zero after reset.
// - software reset lives at address 0x56.
// - writing one to bit 0 restores all registers and alarms.
// - reset request clears itself; reads return zero.
// - upper fifteen bits of reset register have no effect.
// - status register is read-only; upper eleven bits read zero.
// - status bit 4 flags a frame check failure.
// - status bit 3 flags watchdog expiry.
// - status bit 2 flags open load or compliance fault.
// - status bit 1 reads one while the code is ramping.
// - status bit 0 flags die temperature above 142 C.
// - alarms follow current and temperature monitors every monitoring cycle.
// - alarm holds until cause resolves, software reset, or power-up.
// - alarm persisting into the next monitoring cycle is set again.
// - trim enable applies gain and offset trims to the code.
// - ramping only with ramp enable; otherwise output jumps at once.
`default_nettype none
module cdr_top #(
  parameter int CODE_BITS = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [6:0] i_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [15:0] o_rd_data,
  input wire logic i_frame_check_fault,
  input wire logic i_watchdog_expired_fault,
  input wire logic i_load_fault,
  input wire logic i_overtemp_fault,
  input wire logic i_monitor_tick,
  output logic [15:0] o_current_output_code,
  output logic o_ramp_active,
  output logic o_irq
);

  // keeps only the implemented code bits
  localparam logic [15:0] CODE_MASK = 16'(16'hFFFF << (16 - CODE_BITS));

  // reset release synchroniser
  logic rst_meta_reg;
  logic rst_sync_n_reg;

  // registers
  logic [15:0] output_code_reg;
  logic [15:0] gain_trim_reg;
  logic [15:0] offset_trim_reg;
  logic [cdr_pkg::CTRL_W-1:0] ctrl_reg;
  logic [cdr_pkg::ST_W-1:0] alarm_reg;
  logic [cdr_pkg::ST_W-1:0] alarm_next;
  logic [cdr_pkg::ST_W-1:0] status_prev_reg;
  logic [cdr_pkg::ST_W-1:0] irq_stat_reg;
  logic [cdr_pkg::ST_W-1:0] irq_mask_reg;
  logic [15:0] trimmed_reg;
  logic [15:0] rd_data_reg;
  logic [15:0] dac_code_reg;
  logic irq_reg;
  logic srst_reg;

  // decoded strobes and derived values
  logic wr_code;
  logic wr_gain;
  logic wr_offset;
  logic wr_ctrl;
  logic wr_mask;
  logic wr_reset;
  logic rd_irq;
  logic [cdr_pkg::ST_W-1:0] cause;
  logic [cdr_pkg::ST_W-1:0] status_now;
  logic [cdr_pkg::ST_W-1:0] status_rise;
  logic [15:0] status_word;

  cdr_ramp_if rif ();

  // drops the unimplemented low code bits
  function automatic logic [15:0] cdr_mask(input logic [15:0] v);
    cdr_mask = v & CODE_MASK;
  endfunction

  // widens a status-layout field to a bus word; reserved bits read zero
  function automatic logic [15:0] cdr_pad(input logic [cdr_pkg::ST_W-1:0] v);
    cdr_pad = {11'h000, v};
  endfunction

  // gain then signed offset, saturated to the code range
  function automatic logic [15:0] cdr_trim(input logic [15:0] code,
                                           input logic [15:0] gain,
                                           input logic [15:0] ofs);
    logic [33:0] prod;
    logic signed [18:0] sum;
    prod = {18'h00000, code} * ({18'h00000, gain} + 34'h000010000);
    sum = $signed({3'b000, prod[32:cdr_pkg::GAIN_SHIFT]}) + $signed({{3{ofs[15]}}, ofs});
    if (sum < 0) begin
      cdr_trim = 16'h0000;
    end else if (sum > $signed(19'h0FFFF)) begin
      cdr_trim = 16'hFFFF;
    end else begin
      cdr_trim = sum[15:0];
    end
  endfunction

  // two stage release; assertion stays asynchronous
  // release is synchronous so no flop leaves reset a cycle apart
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n_reg <= rst_meta_reg;
    end
  end

  // one strobe aimed at one register
  function automatic logic cdr_hit(input logic en, input logic [6:0] a,
                                   input logic [6:0] want);
    cdr_hit = en && (a == want);
  endfunction

  // address decode of the strobes
  assign wr_code = cdr_hit(i_wr_en, i_addr, cdr_pkg::ADDR_OUTPUT_CODE);
  assign wr_gain = cdr_hit(i_wr_en, i_addr, cdr_pkg::ADDR_GAIN_TRIM);
  assign wr_offset = cdr_hit(i_wr_en, i_addr, cdr_pkg::ADDR_OFFSET_TRIM);
  assign wr_ctrl = cdr_hit(i_wr_en, i_addr, cdr_pkg::ADDR_RAMP_TRIM_CTRL);
  assign wr_mask = cdr_hit(i_wr_en, i_addr, cdr_pkg::ADDR_IRQ_MASK);
  assign wr_reset = cdr_hit(i_wr_en, i_addr, cdr_pkg::ADDR_SW_RESET);
  assign rd_irq = cdr_hit(i_rd_en, i_addr, cdr_pkg::ADDR_IRQ_STATUS);

  // software reset request; only bit 0 counts, the request is a one-cycle pulse
  // reserved bits are ignored, so writing them changes nothing
  always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      srst_reg <= 1'b0;
    end else begin
      srst_reg <= wr_reset && i_wr_data[cdr_pkg::SW_RESET_BIT];
    end
  end

  // output code register
  // low bits dropped on write so reads and conversion agree
  always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      output_code_reg <= cdr_pkg::OUTPUT_CODE_RESET;
    end else if (srst_reg) begin
      output_code_reg <= cdr_pkg::OUTPUT_CODE_RESET;
    end else if (wr_code) begin
      output_code_reg <= cdr_mask(i_wr_data);
    end
  end

  // gain trim, unsigned
  always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      gain_trim_reg <= cdr_pkg::GAIN_TRIM_RESET;
    end else if (srst_reg) begin
      gain_trim_reg <= cdr_pkg::GAIN_TRIM_RESET;
    end else if (wr_gain) begin
      gain_trim_reg <= cdr_mask(i_wr_data);
    end
  end

  // offset trim, twos complement
  always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      offset_trim_reg <= cdr_pkg::OFFSET_TRIM_RESET;
    end else if (srst_reg) begin
      offset_trim_reg <= cdr_pkg::OFFSET_TRIM_RESET;
    end else if (wr_offset) begin
      offset_trim_reg <= cdr_mask(i_wr_data);
    end
  end

  // ramp and trim settings
  always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      ctrl_reg <= cdr_pkg::CTRL_RESET;
    end else if (srst_reg) begin
      ctrl_reg <= cdr_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= i_wr_data[cdr_pkg::CTRL_W-1:0];
    end
  end

  // interrupt mask
  // mask gates only the pin; irq status records every event
  always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      irq_mask_reg <= cdr_pkg::IRQ_MASK_RESET;
    end else if (srst_reg) begin
      irq_mask_reg <= cdr_pkg::IRQ_MASK_RESET;
    end else if (wr_mask) begin
      irq_mask_reg <= i_wr_data[cdr_pkg::ST_W-1:0];
    end
  end

  // trimmed code, one pipeline stage to keep the multiplier off the ramp path
  // trade-off: a trim write reaches the ramp target one cycle late
  always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      trimmed_reg <= 16'h0000;
    end else if (srst_reg) begin
      trimmed_reg <= 16'h0000;
    end else begin
      trimmed_reg <= cdr_mask(cdr_trim(output_code_reg, gain_trim_reg, offset_trim_reg));
    end
  end

  // ramp engine settings and target
  // trim sits ahead of the ramp, so slewing aims at the trimmed code
  assign rif.target = ctrl_reg[cdr_pkg::CTRL_TRIM_EN] ? trimmed_reg : output_code_reg;
  assign rif.enable = ctrl_reg[cdr_pkg::CTRL_RAMP_EN];
  assign rif.step_sel = ctrl_reg[cdr_pkg::CTRL_STEP_LSB +: cdr_pkg::STEP_W];
  assign rif.clk_sel = ctrl_reg[cdr_pkg::CTRL_CLK_LSB +: cdr_pkg::RCLK_W];

  cdr_ramp u_ramp (
    .i_mclk(i_mclk),
    .i_rst_n(rst_sync_n_reg),
    .i_clear(srst_reg),
    .rp(rif.ramp)
  );

  // alarm causes; ramp bit is not an alarm and is taken from the engine
  // a frame check pulse is enough; the alarm keeps it
  assign cause[cdr_pkg::ST_CRC] = i_frame_check_fault;
  assign cause[cdr_pkg::ST_WDOG] = i_watchdog_expired_fault;
  assign cause[cdr_pkg::ST_LOAD] = i_load_fault;
  assign cause[cdr_pkg::ST_RAMP] = 1'b0;
  assign cause[cdr_pkg::ST_OVERTEMP] = i_overtemp_fault;

  // a present cause always sets; a monitor tick with no cause clears
  // a cause that outlives a tick is therefore never lost
  always_comb begin
    alarm_next = alarm_reg;
    for (int i = 0; i < cdr_pkg::ST_W; i++) begin
      if (cause[i]) begin
        alarm_next[i] = 1'b1;
      end else if (i_monitor_tick) begin
        alarm_next[i] = 1'b0;
      end
    end
  end

  // sticky alarm bits
  always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      alarm_reg <= '0;
    end else if (srst_reg) begin
      alarm_reg <= '0;
    end else begin
      alarm_reg <= alarm_next;
    end
  end

  // status view: alarms plus live ramp state
  always_comb begin
    status_now = alarm_reg;
    status_now[cdr_pkg::ST_RAMP] = rif.active;
  end

  assign status_word = cdr_pad(status_now);
  assign status_rise = status_now & ~status_prev_reg;

  // edge memory for interrupt events
  // cleared with the alarms so a re-raised alarm gives a fresh event
  always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      status_prev_reg <= '0;
    end else if (srst_reg) begin
      status_prev_reg <= '0;
    end else begin
      status_prev_reg <= status_now;
    end
  end

  // sticky interrupt status; read clears, a new event in that cycle wins
  // a held alarm raises one event, not one per cycle
  always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      irq_stat_reg <= '0;
    end else if (srst_reg) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (rd_irq ? '0 : irq_stat_reg) | status_rise;
    end
  end

  // level interrupt, one cycle behind the irq status bits, two behind the status bits
  always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      irq_reg <= 1'b0;
    end else if (srst_reg) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // read mux; write-only and unmapped addresses read zero
  // read-clear of irq status is decoded apart, on the strobe itself
  always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      rd_data_reg <= 16'h0000;
    end else if (i_rd_en) begin
      unique case (i_addr)
        cdr_pkg::ADDR_OUTPUT_CODE: rd_data_reg <= output_code_reg;
        cdr_pkg::ADDR_GAIN_TRIM: rd_data_reg <= gain_trim_reg;
        cdr_pkg::ADDR_OFFSET_TRIM: rd_data_reg <= offset_trim_reg;
        cdr_pkg::ADDR_STATUS: rd_data_reg <= status_word;
        cdr_pkg::ADDR_RAMP_TRIM_CTRL: rd_data_reg <= {7'h00, ctrl_reg};
        cdr_pkg::ADDR_IRQ_STATUS: rd_data_reg <= cdr_pad(irq_stat_reg);
        cdr_pkg::ADDR_IRQ_MASK: rd_data_reg <= cdr_pad(irq_mask_reg);
        cdr_pkg::ADDR_TRIMMED_CODE: rd_data_reg <= trimmed_reg;
        cdr_pkg::ADDR_SW_RESET: rd_data_reg <= 16'h0000;
        default: rd_data_reg <= 16'h0000;
      endcase
    end else begin
      rd_data_reg <= 16'h0000;
    end
  end

  // code presented to the converter, registered at the boundary
  always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      dac_code_reg <= 16'h0000;
    end else if (srst_reg) begin
      dac_code_reg <= 16'h0000;
    end else begin
      dac_code_reg <= rif.current;
    end
  end

  assign o_rd_data = rd_data_reg;
  assign o_current_output_code = dac_code_reg;
  assign o_ramp_active = status_prev_reg[cdr_pkg::ST_RAMP];
  assign o_irq = irq_reg;

endmodule
`default_nettype wire

// ---- cdr_pkg.sv ----
`default_nettype none
package cdr_pkg;
  // bus geometry
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;

  // register map
  localparam logic [6:0] ADDR_OUTPUT_CODE = 7'h40;
  localparam logic [6:0] ADDR_GAIN_TRIM = 7'h41;
  localparam logic [6:0] ADDR_OFFSET_TRIM = 7'h42;
  localparam logic [6:0] ADDR_STATUS = 7'h43;
  localparam logic [6:0] ADDR_RAMP_TRIM_CTRL = 7'h44;
  localparam logic [6:0] ADDR_IRQ_STATUS = 7'h45;
  localparam logic [6:0] ADDR_IRQ_MASK = 7'h46;
  localparam logic [6:0] ADDR_TRIMMED_CODE = 7'h47;
  localparam logic [6:0] ADDR_SW_RESET = 7'h56;

  // values after reset
  localparam logic [15:0] OUTPUT_CODE_RESET = 16'h0000;
  localparam logic [15:0] GAIN_TRIM_RESET = 16'h0000;
  localparam logic [15:0] OFFSET_TRIM_RESET = 16'h0000;
  localparam logic [8:0] CTRL_RESET = 9'h000;
  localparam logic [4:0] IRQ_MASK_RESET = 5'h00;

  // software reset register
  localparam int SW_RESET_BIT = 0;

  // status layout, also used by irq status and mask
  localparam int ST_W = 5;
  localparam int ST_OVERTEMP = 0;
  localparam int ST_RAMP = 1;
  localparam int ST_LOAD = 2;
  localparam int ST_WDOG = 3;
  localparam int ST_CRC = 4;

  // ramp and trim control layout
  localparam int CTRL_W = 9;
  localparam int CTRL_TRIM_EN = 0;
  localparam int CTRL_RAMP_EN = 1;
  localparam int CTRL_STEP_LSB = 2;
  localparam int STEP_W = 3;
  localparam int CTRL_CLK_LSB = 5;
  localparam int RCLK_W = 4;

  // timing
  localparam int CLK_MHZ = 125;
  localparam int RAMP_BASE_NS = 1000;
  localparam int RAMP_BASE_CYC = (RAMP_BASE_NS * CLK_MHZ) / 1000;
  localparam int RAMP_DIV_W = 12;

  // gain trim: code * (65536 + gain) / 2^17
  localparam int GAIN_SHIFT = 17;
endpackage
`default_nettype wire

// ---- cdr_ramp_if.sv ----
`default_nettype none
interface cdr_ramp_if;
  logic [15:0] target;
  logic [15:0] current;
  logic enable;
  logic [2:0] step_sel;
  logic [3:0] clk_sel;
  logic active;
  modport ctl (output target, output enable, output step_sel, output clk_sel,
               input current, input active);
  modport ramp (input target, input enable, input step_sel, input clk_sel,
                output current, output active);
endinterface
`default_nettype wire

// ---- cdr_ramp.sv ----
`default_nettype none
module cdr_ramp (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_clear,
  cdr_ramp_if.ramp rp
);
  logic [cdr_pkg::RAMP_DIV_W-1:0] div_reg;
  logic [cdr_pkg::RAMP_DIV_W-1:0] div_top;
  logic tick;
  logic [15:0] cur_reg;
  logic [15:0] cur_next;
  logic [15:0] step;
  logic active_reg;

  // step period is (clk_sel + 1) base periods
  assign div_top = cdr_pkg::RAMP_DIV_W'((int'(rp.clk_sel) + 1) * cdr_pkg::RAMP_BASE_CYC - 1);
  assign tick = (div_reg == div_top);
  assign step = 16'(16'h0001 << rp.step_sel);

  // step divider, idle while ramping is off
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_reg <= '0;
    end else if (i_clear || !rp.enable || tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // move toward target by one step, never overshoot
  always_comb begin
    cur_next = cur_reg;
    if (!rp.enable) begin
      cur_next = rp.target;
    end else if (tick) begin
      if (rp.target > cur_reg) begin
        cur_next = ((rp.target - cur_reg) > step) ? cur_reg + step : rp.target;
      end else if (rp.target < cur_reg) begin
        cur_next = ((cur_reg - rp.target) > step) ? cur_reg - step : rp.target;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur_reg <= 16'h0000;
      active_reg <= 1'b0;
    end else if (i_clear) begin
      cur_reg <= 16'h0000;
      active_reg <= 1'b0;
    end else begin
      cur_reg <= cur_next;
      active_reg <= rp.enable && (cur_next != rp.target);
    end
  end

  assign rp.current = cur_reg;
  assign rp.active = active_reg;
endmodule
`default_nettype wire

// ---- cdr_properties.sv ----
`default_nettype none
module cdr_checker #(
  parameter int CODE_BITS = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [6:0] i_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [15:0] o_rd_data,
  input wire logic i_frame_check_fault,
  input wire logic i_watchdog_expired_fault,
  input wire logic i_load_fault,
  input wire logic i_overtemp_fault,
  input wire logic i_monitor_tick,
  input wire logic [15:0] o_current_output_code,
  input wire logic o_ramp_active,
  input wire logic o_irq
);
  logic [2:0] quiet_cnt;
  logic quiet;
  logic [15:0] keep_mask;
  logic srst_wr;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  // quiet window: internal resync and software clear both long over
  assign srst_wr = i_wr_en && i_addr == cdr_pkg::ADDR_SW_RESET && i_wr_data[0];
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      quiet_cnt <= 3'h0;
    end else if (srst_wr) begin
      quiet_cnt <= 3'h0;
    end else if (quiet_cnt != 3'h7) begin
      quiet_cnt <= quiet_cnt + 3'h1;
    end
  end
  assign quiet = quiet_cnt == 3'h7;
  assign keep_mask = (CODE_BITS == 12) ? 16'hFFF0 : 16'hFFFF;
  // write, one idle cycle, then a read of the same register
  property wr_rd_p(logic [6:0] a);
    quiet && i_wr_en && i_addr == a ##1 !i_wr_en ##1 i_rd_en && i_addr == a
      |=> o_rd_data == ($past(i_wr_data, 3) & keep_mask);
  endproperty
  property alarm_p(logic c, int b);
    quiet && i_rd_en && i_addr == cdr_pkg::ADDR_STATUS && $past(c) |=> o_rd_data[b];
  endproperty
  code_write_read_a: assert property (wr_rd_p(cdr_pkg::ADDR_OUTPUT_CODE))
    else $error("output code readback wrong");
  gain_write_read_a: assert property (wr_rd_p(cdr_pkg::ADDR_GAIN_TRIM))
    else $error("gain trim readback wrong");
  offset_write_read_a: assert property (wr_rd_p(cdr_pkg::ADDR_OFFSET_TRIM))
    else $error("offset trim readback wrong");
  status_reserved_zero_a: assert property (
    i_rd_en && i_addr == cdr_pkg::ADDR_STATUS |=> o_rd_data[15:5] == 11'h000)
    else $error("status reserved bits not zero");
  reset_reg_zero_a: assert property (
    i_rd_en && i_addr == cdr_pkg::ADDR_SW_RESET |=> o_rd_data == 16'h0000)
    else $error("reset register read not zero");
  crc_alarm_set_a: assert property (alarm_p(i_frame_check_fault, cdr_pkg::ST_CRC))
    else $error("frame check alarm missing");
  wdog_alarm_set_a: assert property (
    alarm_p(i_watchdog_expired_fault, cdr_pkg::ST_WDOG))
    else $error("watchdog alarm missing");
  load_alarm_set_a: assert property (alarm_p(i_load_fault, cdr_pkg::ST_LOAD))
    else $error("load alarm missing");
  temp_alarm_set_a: assert property (
    alarm_p(i_overtemp_fault, cdr_pkg::ST_OVERTEMP))
    else $error("overtemp alarm missing");
  load_alarm_clear_a: assert property (
    quiet && i_monitor_tick && !i_load_fault ##1 !i_load_fault
      ##1 i_rd_en && i_addr == cdr_pkg::ADDR_STATUS |=> !o_rd_data[cdr_pkg::ST_LOAD])
    else $error("load alarm not cleared after resolve");
  srst_irq_low_a: assert property ($past(srst_wr, 4) |-> !o_irq)
    else $error("interrupt survived software reset");
  cover property (srst_wr);
  cover property (o_irq);
  cover property (o_ramp_active);
endmodule
bind cdr_top cdr_checker #(.CODE_BITS(CODE_BITS)) i_checker (.i_mclk, .i_rst_n, .i_addr,
  .i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data, .i_frame_check_fault, .i_watchdog_expired_fault,
  .i_load_fault, .i_overtemp_fault, .i_monitor_tick, .o_current_output_code, .o_ramp_active,
  .o_irq);
`default_nettype wire

// ---- cdr_host_model.sv ----
`default_nettype none
module cdr_host_model (
  input wire logic i_mclk,
  input wire logic [15:0] i_rd_data,
  output logic [6:0] o_addr,
  output logic [15:0] o_wr_data,
  output logic o_wr_en,
  output logic o_rd_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    o_addr = 7'h00;
    o_wr_data = 16'h0000;
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
  end
  // one-cycle write; data inverted after so a stale word never looks valid
  task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_wr_data <= d;
    o_wr_en <= 1'b1;
    @(posedge i_mclk);
    o_wr_en <= 1'b0;
    o_wr_data <= ~d;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [6:0] a, output logic [15:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_rd_en <= 1'b1;
    @(posedge i_mclk);
    o_rd_en <= 1'b0;
    @(negedge i_mclk);
    d = i_rd_data;
  endtask
  task automatic soft_reset(input logic [15:0] d);
    wr_reg(cdr_pkg::ADDR_SW_RESET, d);
  endtask
endmodule
`default_nettype wire

// ---- current_dac_data_status_regs_test.sv ----
`default_nettype none
module current_dac_data_status_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst_n;
  logic [6:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic [15:0] rdata12;
  logic [15:0] code12;
  logic [4:0] flt;
  logic tick;
  logic [15:0] code_out;
  logic ramp;
  logic irq;
  logic [15:0] v [3];
  logic [15:0] d;
  int bad_count;
  int check_count;
  int seed;
  int k;
  int abit [4] = '{0, 2, 3, 4};
  cdr_host_model i_host (.i_mclk(clk), .i_rd_data(rdata), .o_addr(addr), .o_wr_data(wdata),
    .o_wr_en(wr), .o_rd_en(rd));
  cdr_top i_dut (.i_mclk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr_data(wdata), .i_wr_en(wr),
    .i_rd_en(rd), .o_rd_data(rdata), .i_frame_check_fault(flt[4]),
    .i_watchdog_expired_fault(flt[3]), .i_load_fault(flt[2]), .i_overtemp_fault(flt[0]),
    .i_monitor_tick(tick), .o_current_output_code(code_out), .o_ramp_active(ramp), .o_irq(irq));
  // narrow variant on the same bus and monitors
  cdr_top #(.CODE_BITS(12)) i_dut_narrow (.i_mclk(clk), .i_rst_n(rst_n), .i_addr(addr),
    .i_wr_data(wdata), .i_wr_en(wr), .i_rd_en(rd), .o_rd_data(rdata12),
    .i_frame_check_fault(flt[4]), .i_watchdog_expired_fault(flt[3]), .i_load_fault(flt[2]),
    .i_overtemp_fault(flt[0]), .i_monitor_tick(tick), .o_current_output_code(code12),
    .o_ramp_active(), .o_irq());
  // 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic rc(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] got;
    i_host.rd_reg(a, got);
    check(got, exp);
  endtask
  // sample away from the edge so the design's updates have landed
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic pulse_tick();
    @(posedge clk) tick <= 1'b1;
    @(posedge clk) tick <= 1'b0;
  endtask
  // trimmed code, saturated to the unsigned range
  function automatic logic [15:0] trim_exp(input logic [15:0] c, input logic [15:0] g,
                                           input logic [15:0] o);
    longint t;
    t = longint'(c) * (65536 + longint'(g)) / 131072 + longint'($signed(o));
    if (t < 0) return 16'h0000;
    if (t > 65535) return 16'hFFFF;
    return 16'(t);
  endfunction
  // hang guard: the sequence needs well under 3000 cycles
  initial begin
    repeat (6000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
  initial begin
    seed = 32'h34E9;
    bad_count = 0;
    check_count = 0;
    rst_n = 1'b0;
    flt = 5'h00;
    tick = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (k = 0; k < 4; k++) rc(7'(cdr_pkg::ADDR_OUTPUT_CODE + k), 16'h0000);
    rc(cdr_pkg::ADDR_SW_RESET, 16'h0000);
    i_host.wr_reg(7'h7F, 16'hFFFF);
    rc(7'h7F, 16'h0000);
    $display("test defaults done");
    repeat (16) begin
      k = $unsigned($random(seed)) % 3;
      d = 16'($random(seed));
      i_host.wr_reg(7'(cdr_pkg::ADDR_OUTPUT_CODE + k), d);
      rc(7'(cdr_pkg::ADDR_OUTPUT_CODE + k), d);
      check(rdata12, d & 16'hFFF0);
    end
    i_host.wr_reg(cdr_pkg::ADDR_STATUS, 16'hFFFF);
    rc(cdr_pkg::ADDR_STATUS, 16'h0000);
    $display("test random words done");
    // each alarm: read while the cause outlives a tick, then resolve it
    foreach (abit[i]) begin
      @(posedge clk) flt[abit[i]] <= 1'b1;
      pulse_tick();
      rc(cdr_pkg::ADDR_STATUS, 16'h0001 << abit[i]);
      @(posedge clk) flt[abit[i]] <= 1'b0;
      rc(cdr_pkg::ADDR_STATUS, 16'h0001 << abit[i]);
      pulse_tick();
      rc(cdr_pkg::ADDR_STATUS, 16'h0000);
    end
    $display("test alarms done");
    rc(cdr_pkg::ADDR_IRQ_STATUS, 16'h001D);
    rc(cdr_pkg::ADDR_IRQ_STATUS, 16'h0000);
    i_host.wr_reg(cdr_pkg::ADDR_IRQ_MASK, 16'h0004);
    @(posedge clk) flt[2] <= 1'b1;
    settle(4);
    check({15'h0000, irq}, 16'h0001);
    rc(cdr_pkg::ADDR_IRQ_STATUS, 16'h0004);
    settle(3);
    check({15'h0000, irq}, 16'h0000);
    $display("test interrupt done");
    // load fault stays high across both reset writes
    for (k = 0; k < 3; k++) begin
      v[k] = 16'($random(seed));
      i_host.wr_reg(7'(cdr_pkg::ADDR_OUTPUT_CODE + k), v[k]);
    end
    i_host.soft_reset(16'hFFFE);
    for (k = 0; k < 3; k++) rc(7'(cdr_pkg::ADDR_OUTPUT_CODE + k), v[k]);
    i_host.soft_reset(16'h8001);
    settle(8);
    check({15'h0000, irq}, 16'h0000);
    for (k = 0; k < 3; k++) rc(7'(cdr_pkg::ADDR_OUTPUT_CODE + k), 16'h0000);
    rc(cdr_pkg::ADDR_IRQ_MASK, 16'h0000);
    rc(cdr_pkg::ADDR_STATUS, 16'h0004);
    rc(cdr_pkg::ADDR_SW_RESET, 16'h0000);
    @(posedge clk) flt[2] <= 1'b0;
    pulse_tick();
    $display("test software reset done");
    d = 16'($random(seed));
    i_host.wr_reg(cdr_pkg::ADDR_OUTPUT_CODE, d);
    settle(3);
    check(code_out, d);
    check(code12, d & 16'hFFF0);
    v[1] = 16'($random(seed));
    v[2] = 16'($random(seed));
    i_host.wr_reg(cdr_pkg::ADDR_GAIN_TRIM, v[1]);
    i_host.wr_reg(cdr_pkg::ADDR_OFFSET_TRIM, v[2]);
    i_host.wr_reg(cdr_pkg::ADDR_RAMP_TRIM_CTRL, 16'h0001);
    settle(4);
    check(code_out, trim_exp(d, v[1], v[2]));
    rc(cdr_pkg::ADDR_TRIMMED_CODE, trim_exp(d, v[1], v[2]));
    i_host.wr_reg(cdr_pkg::ADDR_RAMP_TRIM_CTRL, 16'h0000);
    i_host.wr_reg(cdr_pkg::ADDR_OUTPUT_CODE, 16'h0000);
    settle(3);
    i_host.wr_reg(cdr_pkg::ADDR_RAMP_TRIM_CTRL, 16'h0002);
    i_host.wr_reg(cdr_pkg::ADDR_OUTPUT_CODE, 16'h0003);
    settle(6);
    check({15'h0000, ramp}, 16'h0001);
    rc(cdr_pkg::ADDR_STATUS, 16'h0002);
    settle(500);
    check({15'h0000, ramp}, 16'h0000);
    check(code_out, 16'h0003);
    $display("test output path done");
    give_verdict();
  end
endmodule
`default_nettype wire
